// [include/arc_pkg.sv]
/*
  Constants, register map and state types of the autoreclose sequencer.
  Assumes a 50 MHz clock; all time settings are held in tenths of a second.
*/
package arc_pkg;
  // clock and timing base
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned TICK_MS = 100;
  localparam int unsigned TICK_CYC = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned TW = 14;
  localparam int unsigned AW = 6;
  localparam int unsigned DW = 16;

  // register byte addresses
  localparam logic [AW-1:0] ADR_CTRL = 6'h00;
  localparam logic [AW-1:0] ADR_RSTW = 6'h04;
  localparam logic [AW-1:0] ADR_DWELL = 6'h08;
  localparam logic [AW-1:0] ADR_HOLD = 6'h0C;
  localparam logic [AW-1:0] ADR_SPD = 6'h10;
  localparam logic [AW-1:0] ADR_TPD = 6'h20;
  localparam logic [AW-1:0] ADR_STAT = 6'h30;

  // control field positions
  localparam int unsigned F_MODE = 0;
  localparam int unsigned F_PROG = 3;
  localparam int unsigned F_TPM = 5;
  localparam int unsigned F_SUP = 6;
  localparam int unsigned F_HNC = 7;
  localparam int unsigned F_SPN = 8;
  localparam int unsigned F_TPN = 10;

  // operating modes and programs
  localparam logic [2:0] MD_NONE = 3'h0;
  localparam logic [2:0] MD_INT = 3'h1;
  localparam logic [2:0] MD_EXT = 3'h2;
  localparam logic [2:0] MD_BOTH = 3'h3;
  localparam logic [2:0] MD_OFF = 3'h4;
  localparam logic [1:0] PG_SP = 2'h0;
  localparam logic [1:0] PG_TP = 2'h1;
  localparam logic [1:0] PG_MIX = 2'h2;

  // reset values
  localparam logic [DW-1:0] CTRL_RST = 16'h0000;
  localparam logic [TW-1:0] RSTW_RST = 14'h0064;
  localparam logic [TW-1:0] DWELL_RST = 14'h0005;
  localparam logic [TW-1:0] HOLD_RST = 14'h0064;
  localparam logic [TW-1:0] DLY_RST = 14'h000A;

  typedef enum logic [1:0] {ST_RESET, ST_TIMING, ST_DWELL, ST_LOCKOUT} arc_state_t;
  typedef enum logic [1:0] {PH_DELAY, PH_HOLD, PH_RESWAIT} arc_phase_t;
endpackage

// [design/arc_sequencer.sv]
/*
  Autoreclose sequencer: mode and program select, one to four timed shots,
  hold supervision, cancel, lockout and reset handling, register port.
  Assumes contact inputs are asynchronous pins and the internal
  initiates come from logic on clk.
*/
// The address map and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ns
module arc_sequencer
  import arc_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [AW-1:0] addr,
  input wire logic [DW-1:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [DW-1:0] rd_data,
  input wire logic int_single_pole_initiate,
  input wire logic int_three_pole_initiate,
  input wire logic ext_single_pole_initiate,
  input wire logic ext_three_pole_initiate,
  input wire logic [2:0] breaker_open,
  input wire logic hold_in,
  input wire logic cancel_in,
  input wire logic lockout_in,
  input wire logic reset_in,
  output logic close_out,
  output logic three_pole_trip_enable,
  output logic cycle_active_flag,
  output logic lockout_out
);
  localparam int unsigned CW = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;
  localparam logic [CW-1:0] TICK_LAST = CW'(TICK_CYCLES - 1);

  if (TICK_CYCLES < 1) begin : g_chk
    $error("tick length must be at least one cycle");
  end

  typedef struct packed {
    logic [8:0] s1;
    logic [8:0] s2;
    logic [1:0] prev_ini;
    logic prev_lo;
    logic prev_closed;
    logic [DW-1:0] ctrl;
    logic [TW-1:0] rst_t;
    logic [TW-1:0] dwell_t;
    logic [TW-1:0] hold_t;
    logic [7:0][TW-1:0] dly;
    logic [CW-1:0] tick_cnt;
    logic [TW-1:0] timer;
    arc_state_t st;
    arc_phase_t ph;
    logic seq_tp;
    logic [2:0] shot;
    logic cancel_pend;
    logic mc_wait;
    logic [DW-1:0] rd_data;
    logic close;
    logic tpte;
    logic cyc;
    logic lko;
  } arc_regs_t;

  localparam arc_regs_t R_INIT = '{
    st: ST_RESET,
    ph: PH_DELAY,
    ctrl: CTRL_RST,
    rst_t: RSTW_RST,
    dwell_t: DWELL_RST,
    hold_t: HOLD_RST,
    dly: {8{DLY_RST}},
    default: '0
  };

  arc_regs_t r;
  arc_regs_t n;

  // synchronised pins
  logic [2:0] brk_open_s;
  logic hold_s;
  logic cancel_s;
  logic lock_s;
  logic reset_s;
  logic ext_sp_s;
  logic ext_tp_s;
  // decoded settings
  logic [2:0] mode;
  logic [1:0] prog;
  logic tpm_single;
  logic sup_en;
  logic [2:0] nshots;
  logic [2:0] next_mode;
  logic [1:0] next_prog;
  // events
  logic tick;
  logic act_mode;
  logic sp_lvl;
  logic tp_lvl;
  logic ini_sp;
  logic ini_tp;
  logic fault;
  logic released;
  logic brk_closed;
  logic start_tp;
  logic start_lock;

  assign brk_open_s = r.s2[2:0];
  assign hold_s = r.s2[3];
  assign cancel_s = r.s2[4];
  assign lock_s = r.s2[5];
  assign reset_s = r.s2[6];
  assign ext_sp_s = r.s2[7];
  assign ext_tp_s = r.s2[8];

  assign mode = r.ctrl[F_MODE +: 3];
  assign prog = r.ctrl[F_PROG +: 2];
  assign tpm_single = r.ctrl[F_TPM];
  assign sup_en = r.ctrl[F_SUP];

  always_comb begin
    n = r;
    n.s1 = {ext_three_pole_initiate, ext_single_pole_initiate, reset_in,
            lockout_in, cancel_in, hold_in, breaker_open};
    n.s2 = r.s1;

    // register port
    n.rd_data = '0;
    if (wr_en) begin
      if (addr == ADR_CTRL) begin
        n.ctrl = wr_data;
      end else if (addr == ADR_RSTW) begin
        n.rst_t = wr_data[TW-1:0];
      end else if (addr == ADR_DWELL) begin
        n.dwell_t = wr_data[TW-1:0];
      end else if (addr == ADR_HOLD) begin
        n.hold_t = wr_data[TW-1:0];
      end else if (addr[5:4] == ADR_SPD[5:4] || addr[5:4] == ADR_TPD[5:4]) begin
        n.dly[{addr[5], addr[3:2]}] = wr_data[TW-1:0];
      end
    end
    if (rd_en) begin
      if (addr == ADR_CTRL) begin
        n.rd_data = r.ctrl;
      end else if (addr == ADR_RSTW) begin
        n.rd_data = {2'h0, r.rst_t};
      end else if (addr == ADR_DWELL) begin
        n.rd_data = {2'h0, r.dwell_t};
      end else if (addr == ADR_HOLD) begin
        n.rd_data = {2'h0, r.hold_t};
      end else if (addr[5:4] == ADR_SPD[5:4] || addr[5:4] == ADR_TPD[5:4]) begin
        n.rd_data = {2'h0, r.dly[{addr[5], addr[3:2]}]};
      end else if (addr == ADR_STAT) begin
        n.rd_data = {4'h0, r.shot, r.ph, r.st, r.mc_wait, r.lko, r.cyc,
                     r.close, r.tpte};
      end
    end

    // 0.1 s timing base
    tick = (r.tick_cnt == TICK_LAST);
    n.tick_cnt = tick ? '0 : r.tick_cnt + 1'b1;
    if (tick && r.timer != '0) begin
      n.timer = r.timer - 1'b1;
    end

    // initiate source filter
    act_mode = (mode == MD_INT) || (mode == MD_EXT) || (mode == MD_BOTH);
    sp_lvl = ((mode == MD_INT || mode == MD_BOTH) && int_single_pole_initiate) ||
             ((mode == MD_EXT || mode == MD_BOTH) && ext_sp_s);
    tp_lvl = ((mode == MD_INT || mode == MD_BOTH) && int_three_pole_initiate) ||
             ((mode == MD_EXT || mode == MD_BOTH) && ext_tp_s);
    ini_sp = sp_lvl && !r.prev_ini[0];
    ini_tp = tp_lvl && !r.prev_ini[1];
    n.prev_ini = {tp_lvl, sp_lvl};
    fault = ini_sp || ini_tp;

    released = r.ctrl[F_HNC] ? hold_s : !hold_s;
    brk_closed = !(|brk_open_s);
    n.prev_closed = brk_closed;
    n.prev_lo = lock_s;
    nshots = r.seq_tp ? ({1'b0, r.ctrl[F_TPN +: 2]} + 3'h1)
                      : ({1'b0, r.ctrl[F_SPN +: 2]} + 3'h1);

    // program selection at first trip
    start_tp = 1'b1;
    start_lock = 1'b0;
    unique case (prog)
      PG_SP: begin
        start_tp = 1'b0;
        start_lock = !tpm_single || !ini_sp;
      end
      PG_TP: begin
        start_lock = tpm_single || !ini_tp;
      end
      default: begin
        start_tp = ini_sp ? !tpm_single : 1'b1;
        start_lock = (prog != PG_MIX);
      end
    endcase

    unique case (r.st)
      ST_RESET: begin
        if (act_mode && !cancel_s && fault) begin
          if (start_lock) begin
            n.st = ST_LOCKOUT;
          end else begin
            n.st = ST_TIMING;
            n.ph = PH_DELAY;
            n.seq_tp = start_tp;
            n.shot = 3'h0;
            n.timer = r.dly[{start_tp, 2'b00}];
          end
        end
      end
      ST_TIMING: begin
        if (cancel_s) begin
          n.st = ST_LOCKOUT;
        end else begin
          unique case (r.ph)
            PH_DELAY: begin
              if (r.timer == '0) begin
                if (!sup_en || released) begin
                  n.st = ST_DWELL;
                  n.timer = r.dwell_t;
                end else begin
                  n.ph = PH_HOLD;
                  n.timer = r.hold_t;
                end
              end
            end
            PH_HOLD: begin
              if (released) begin
                n.st = ST_DWELL;
                n.timer = r.dwell_t;
              end else if (r.timer == '0) begin
                n.st = ST_LOCKOUT;
              end
            end
            default: begin
              if (fault) begin
                if (r.shot >= nshots || !ini_tp) begin
                  n.st = ST_LOCKOUT;
                end else begin
                  n.ph = PH_DELAY;
                  n.timer = r.dly[{r.seq_tp, r.shot[1:0]}];
                end
              end else if (r.timer == '0) begin
                n.st = ST_RESET;
              end
            end
          endcase
        end
      end
      ST_DWELL: begin
        if (cancel_s) begin
          n.cancel_pend = 1'b1;
        end
        if (r.timer == '0) begin
          if (r.cancel_pend || cancel_s) begin
            n.st = ST_LOCKOUT;
          end else begin
            n.st = ST_TIMING;
            n.ph = PH_RESWAIT;
            n.shot = r.shot + 3'h1;
            n.timer = r.rst_t;
          end
        end
      end
      ST_LOCKOUT: begin
        if (lock_s) begin
          n.mc_wait = 1'b0;
        end else if (r.prev_lo && brk_closed) begin
          n.st = ST_RESET;
        end else if (reset_s && brk_closed) begin
          n.st = ST_RESET;
        end else if (r.mc_wait) begin
          if (fault) begin
            n.mc_wait = 1'b0;
          end else if (r.timer == '0) begin
            n.st = ST_RESET;
          end
        end else if (brk_closed && !r.prev_closed) begin
          n.mc_wait = 1'b1;
          n.timer = r.rst_t;
        end
      end
    endcase

    if (lock_s) begin
      n.st = ST_LOCKOUT;
    end
    // manual close wait only lives inside lockout
    if (n.st != ST_LOCKOUT || r.st != ST_LOCKOUT) begin
      n.mc_wait = 1'b0;
    end
    if (n.st != ST_DWELL) begin
      n.cancel_pend = 1'b0;
    end
    // tick base restarts on each load, so a count of n lasts n full ticks
    if (n.st != r.st || n.ph != r.ph || n.mc_wait != r.mc_wait) begin
      n.tick_cnt = '0;
    end

    // outputs follow the next state
    next_mode = n.ctrl[F_MODE +: 3];
    next_prog = n.ctrl[F_PROG +: 2];
    n.close = (n.st == ST_DWELL);
    n.lko = (n.st == ST_LOCKOUT);
    n.cyc = (n.st == ST_TIMING) || (n.st == ST_DWELL);
    n.tpte = (next_mode != MD_NONE) &&
             ((next_mode == MD_OFF) || n.lko ||
              (next_prog == PG_TP) ||
              (n.cyc && (n.seq_tp || n.shot != 3'h0)));
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      r <= R_INIT;
    end else begin
      r <= n;
    end
  end

  assign rd_data = r.rd_data;
  assign close_out = r.close;
  assign three_pole_trip_enable = r.tpte;
  assign cycle_active_flag = r.cyc;
  assign lockout_out = r.lko;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_hold_expire;
    r.st == ST_TIMING && r.ph == PH_HOLD && r.timer == '0 && !released;
  endsequence

  sequence s_quiet;
    !cancel_s && !lock_s;
  endsequence

  property p_none_no_tpte;
    (mode == MD_NONE) |-> !three_pole_trip_enable;
  endproperty
  a_none_no_tpte: assert property (p_none_no_tpte)
    else $error("trip enable high in mode none");

  property p_off_blocks;
    (mode == MD_OFF && r.st == ST_RESET && !lock_s) |->
      three_pole_trip_enable ##1 r.st == ST_RESET;
  endproperty
  a_off_blocks: assert property (p_off_blocks)
    else $error("mode off left reset or dropped trip enable");

  property p_lockout_tpte;
    (lockout_out && mode != MD_NONE) |-> three_pole_trip_enable;
  endproperty
  a_lockout_tpte: assert property (p_lockout_tpte)
    else $error("trip enable low in lockout");

  property p_flags;
    (lockout_out == (r.st == ST_LOCKOUT)) && !(cycle_active_flag && lockout_out);
  endproperty
  a_flags: assert property (p_flags)
    else $error("cycle and lockout flags disagree with state");

  property p_close_dwell;
    $rose(close_out) |-> (r.st == ST_DWELL && r.timer == r.dwell_t);
  endproperty
  a_close_dwell: assert property (p_close_dwell)
    else $error("close pulse not loaded with dwell time");

  property p_cancel_cycle;
    (r.st == ST_TIMING && cancel_s) |=> (r.st == ST_LOCKOUT && lockout_out);
  endproperty
  a_cancel_cycle: assert property (p_cancel_cycle)
    else $error("cancel in cycle did not lock out");

  property p_lock_in;
    lock_s |=> lockout_out [*1];
  endproperty
  a_lock_in: assert property (p_lock_in)
    else $error("lockout input did not force lockout");

  property p_reset_in;
    (r.st == ST_LOCKOUT && reset_s && brk_closed && !lock_s) |=> r.st == ST_RESET;
  endproperty
  a_reset_in: assert property (p_reset_in)
    else $error("reset input with breaker closed ignored");

  property p_hold_expire;
    s_hold_expire ##0 s_quiet |=> (r.st == ST_LOCKOUT && !close_out);
  endproperty
  a_hold_expire: assert property (p_hold_expire)
    else $error("hold wait expired without lockout");
endmodule

// [dv/arc_breaker_model.sv]
/*
  Breaker model for the autoreclose sequencer bench: per-pole open
  contacts (one contact in three-pole schemes) that open on a trip and close on the close command.
  Assumes trip and manual close pulses come from the bench on clk.
*/
`timescale 1ns/1ns
module arc_breaker_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic close_out,
  input wire logic man_close,
  input wire logic three_pole_scheme,
  input wire logic [2:0] trip,
  output logic [2:0] breaker_open
);
  // one contact in three-pole schemes, one per pole otherwise
  always_ff @(posedge clk) begin
    if (rst) begin
      breaker_open <= 3'h0;
    end else if (close_out || man_close) begin
      breaker_open <= 3'h0;
    end else if (trip != 3'h0) begin
      breaker_open <= three_pole_scheme ? 3'h1 : (breaker_open | trip);
    end
  end
endmodule

// [dv/tb_top.sv]
/*
  Self-checking bench of the autoreclose sequencer: register port tasks,
  a table of fault scenarios, lockout and reset input handling.
  Assumes the breaker model in its own file and a short tick parameter.
*/
`timescale 1ns/1ns
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin mismatches++; \
  $display("[ERR] %0t got %0h exp %0h", $time, (a), (e)); end end
module tb_top;
  import arc_pkg::*;
  localparam int unsigned TK = 4;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [AW-1:0] addr = 6'h00;
  logic [DW-1:0] wr_data = 16'h0000;
  logic [DW-1:0] rd_data;
  logic wr_en = 1'b0, rd_en = 1'b0, hold_in = 1'b0, cancel_in = 1'b0;
  logic lockout_in = 1'b0, reset_in = 1'b0, man_close = 1'b0, scheme = 1'b0;
  logic [3:0] ini = 4'h0;
  logic [2:0] trip = 3'h0;
  logic [2:0] breaker_open;
  logic close_out, three_pole_trip_enable, cycle_active_flag, lockout_out;
  logic [15:0] s;
  int mismatches = 0, cmp_count = 0, n_close = 0, cur_len = 0, last_len = 0, n0 = 0;

  always #10 clk = ~clk;

  // close pulse counter and length
  always @(negedge clk) begin
    if (close_out === 1'b1) begin
      cur_len++;
    end else if (cur_len != 0) begin
      last_len = cur_len;
      n_close++;
      cur_len = 0;
    end
  end

  arc_sequencer #(.TICK_CYCLES(TK)) arc_sequencer_inst (
    .clk(clk), .rst(rst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
    .rd_en(rd_en), .rd_data(rd_data),
    .int_single_pole_initiate(ini[0]), .int_three_pole_initiate(ini[1]),
    .ext_single_pole_initiate(ini[2]), .ext_three_pole_initiate(ini[3]),
    .breaker_open(breaker_open), .hold_in(hold_in), .cancel_in(cancel_in),
    .lockout_in(lockout_in), .reset_in(reset_in), .close_out(close_out),
    .three_pole_trip_enable(three_pole_trip_enable),
    .cycle_active_flag(cycle_active_flag), .lockout_out(lockout_out)
  );

  arc_breaker_model arc_breaker_model_inst (
    .clk(clk), .rst(rst), .close_out(close_out), .man_close(man_close),
    .three_pole_scheme(scheme), .trip(trip), .breaker_open(breaker_open)
  );

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [AW-1:0] a, output logic [DW-1:0] d);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    @(negedge clk);
    d = rd_data;
    @(posedge clk);
  endtask

  // trip the breaker, then raise one initiate: 0 int single .. 3 ext three
  task automatic fault(input logic ex, input logic sp);
    @(posedge clk);
    trip <= sp ? 3'h1 : 3'h7;
    @(posedge clk);
    trip <= 3'h0;
    ini <= 4'h1 << {ex, ~sp};
    tick(4);
    ini <= 4'h0;
  endtask

  // close the breaker by hand; leave lockout by the reset input
  task automatic recover();
    logic [15:0] st;
    rd(ADR_STAT, st);
    man_close <= 1'b1;
    tick(1);
    man_close <= 1'b0;
    if (st[6:5] === ST_LOCKOUT) begin
      tick(6);
      reset_in <= 1'b1;
      tick(4);
      reset_in <= 1'b0;
      tick(6);
      rd(ADR_STAT, st);
      `CHK(st[6:5], ST_RESET)
    end
    tick(40);
  endtask

  task automatic row(input logic [2:0] md, input logic [1:0] pg, input logic tpm, sup, hnc,
                     cn, ex, sp, input logic [1:0] spn, input logic rf, input int ncl,
                     input logic [1:0] st, input logic [1:0] tp);
    int c0;
    c0 = n_close;
    scheme <= ~tpm;
    wr(ADR_CTRL, (16'(md) << F_MODE) | (16'(pg) << F_PROG) | (16'(tpm) << F_TPM) |
       (16'(sup) << F_SUP) | (16'(hnc) << F_HNC) | (16'(spn) << F_SPN));
    cancel_in <= cn;
    tick(4);
    fault(ex, sp);
    @(negedge clk);
    `CHK(cycle_active_flag, 1'(ncl > 0 || sup))
    if (rf) begin
      repeat (100) begin
        @(posedge clk);
        if (n_close > c0) break;
      end
      @(negedge clk);
      `CHK(three_pole_trip_enable, 1'b1)
      fault(1'b0, 1'b0);
    end
    tick(120);
    `CHK(n_close - c0, ncl)
    if (ncl > 0) `CHK(1'(last_len >= 2 * TK && last_len <= 3 * TK + 1), 1'b1)
    rd(ADR_STAT, s);
    `CHK(s[6:5], st)
    `CHK(lockout_out, 1'(st == ST_LOCKOUT))
    `CHK(cycle_active_flag, 1'b0)
    if (tp != 2'h2) `CHK(three_pole_trip_enable, tp[0])
    cancel_in <= 1'b0;
    recover();
  endtask

  task automatic results();
    if (mismatches == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    tick(30000);
    mismatches++;
    results();
  end

  initial begin
    tick(4);
    rst <= 1'b0;
    rd(ADR_CTRL, s);
    `CHK(s, CTRL_RST)
    rd(ADR_RSTW, s);
    `CHK(s, 16'(RSTW_RST))
    rd(ADR_DWELL, s);
    `CHK(s, 16'(DWELL_RST))
    rd(ADR_HOLD, s);
    `CHK(s, 16'(HOLD_RST))
    for (int i = 0; i < 8; i++) begin
      rd(ADR_SPD + 6'(4 * i), s);
      `CHK(s, 16'(DLY_RST))
    end
    wr(ADR_STAT, 16'hFFFF);
    rd(ADR_STAT, s);
    `CHK(s, 16'h0000)
    wr(6'h34, 16'hFFFF);
    rd(6'h34, s);
    `CHK(s, 16'h0000)
    wr(ADR_RSTW, 16'hFFFF);
    rd(ADR_RSTW, s);
    `CHK(s, 16'h3FFF)
    wr(ADR_RSTW, 16'h0006);
    wr(ADR_DWELL, 16'h0002);
    wr(ADR_HOLD, 16'h0003);
    for (int i = 0; i < 8; i++) wr(ADR_SPD + 6'(4 * i), 16'h0001);
    row(MD_NONE, PG_SP, 1, 0, 0, 0, 0, 1, 0, 0, 0, ST_RESET, 0);
    row(MD_OFF, PG_SP, 1, 0, 0, 0, 0, 1, 0, 0, 0, ST_RESET, 1);
    row(MD_INT, PG_SP, 1, 0, 0, 0, 1, 1, 0, 0, 0, ST_RESET, 2);
    row(MD_INT, PG_SP, 1, 0, 0, 0, 0, 1, 0, 0, 1, ST_RESET, 2);
    row(MD_EXT, PG_SP, 1, 0, 0, 0, 0, 1, 0, 0, 0, ST_RESET, 2);
    row(MD_EXT, PG_SP, 1, 0, 0, 0, 1, 1, 0, 0, 1, ST_RESET, 2);
    row(MD_BOTH, PG_SP, 1, 0, 0, 0, 1, 1, 0, 0, 1, ST_RESET, 2);
    row(MD_BOTH, PG_SP, 1, 0, 0, 0, 0, 1, 0, 0, 1, ST_RESET, 2);
    row(MD_INT, PG_SP, 1, 0, 0, 0, 0, 0, 0, 0, 0, ST_LOCKOUT, 1);
    row(MD_INT, PG_TP, 0, 0, 0, 0, 0, 0, 0, 0, 1, ST_RESET, 1);
    row(MD_INT, PG_TP, 0, 0, 0, 0, 0, 1, 0, 0, 0, ST_LOCKOUT, 1);
    row(MD_INT, PG_TP, 1, 0, 0, 0, 0, 0, 0, 0, 0, ST_LOCKOUT, 1);
    row(MD_INT, PG_SP, 0, 0, 0, 0, 0, 1, 0, 0, 0, ST_LOCKOUT, 1);
    row(MD_INT, PG_MIX, 1, 0, 0, 0, 0, 1, 0, 0, 1, ST_RESET, 2);
    row(MD_INT, PG_MIX, 1, 0, 0, 0, 0, 0, 0, 0, 1, ST_RESET, 2);
    row(MD_INT, PG_SP, 1, 0, 0, 0, 0, 1, 0, 1, 1, ST_LOCKOUT, 1);
    row(MD_INT, PG_SP, 1, 0, 0, 0, 0, 1, 1, 1, 2, ST_RESET, 2);
    row(MD_INT, PG_SP, 1, 1, 0, 0, 0, 1, 0, 0, 1, ST_RESET, 2);
    row(MD_INT, PG_SP, 1, 1, 1, 0, 0, 1, 0, 0, 0, ST_LOCKOUT, 1);
    row(MD_INT, PG_SP, 1, 0, 0, 1, 0, 1, 0, 0, 0, ST_RESET, 2);
    wr(ADR_CTRL, 16'h0000);
    scheme <= 1'b1;
    trip <= 3'h7;
    tick(1);
    trip <= 3'h0;
    lockout_in <= 1'b1;
    tick(6);
    rd(ADR_STAT, s);
    `CHK(s[6:5], ST_LOCKOUT)
    `CHK(lockout_out, 1'b1)
    lockout_in <= 1'b0;
    tick(6);
    rd(ADR_STAT, s);
    `CHK(s[6:5], ST_LOCKOUT)
    reset_in <= 1'b1;
    tick(4);
    reset_in <= 1'b0;
    tick(6);
    rd(ADR_STAT, s);
    `CHK(s[6:5], ST_LOCKOUT)
    man_close <= 1'b1;
    tick(1);
    man_close <= 1'b0;
    tick(60);
    rd(ADR_STAT, s);
    `CHK(s[6:5], ST_RESET)
    lockout_in <= 1'b1;
    tick(6);
    lockout_in <= 1'b0;
    tick(6);
    rd(ADR_STAT, s);
    `CHK(s[6:5], ST_RESET)
    // hold arrives inside the hold wait: close follows
    scheme <= 1'b0;
    n0 = n_close;
    wr(ADR_CTRL, (16'(MD_INT) << F_MODE) | (16'h0001 << F_TPM) |
       (16'h0001 << F_SUP) | (16'h0001 << F_HNC));
    fault(1'b0, 1'b1);
    tick(6);
    hold_in <= 1'b1;
    tick(60);
    hold_in <= 1'b0;
    `CHK(n_close - n0, 1)
    rd(ADR_STAT, s);
    `CHK(s[6:5], ST_RESET)
    // cancel during the shot delay locks out
    wr(ADR_SPD, 16'h0014);
    wr(ADR_CTRL, (16'(MD_INT) << F_MODE) | (16'h0001 << F_TPM));
    fault(1'b0, 1'b1);
    cancel_in <= 1'b1;
    tick(6);
    rd(ADR_STAT, s);
    `CHK(s[6:5], ST_LOCKOUT)
    `CHK(n_close - n0, 1)
    cancel_in <= 1'b0;
    results();
  end
endmodule
